// ---- hw/control_mode_strap_decoder.v ----
// Control mode strap decoder: resolves the mode, edge and calibration
// delay straps, latches a static configuration, and routes the serial
// configuration pins when extended control mode is strapped.
// Assumes window comparators on each strap pin and a classic Wishbone
// master on the system clock.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "strap_map.vh"

module control_mode_strap_decoder (
    input wire clk_i,                      // System clock, 100 MHz
    input wire rst_i,                      // Synchronous reset, active high
    input wire mode_strap_above_i,         // Mode strap above high threshold
    input wire mode_strap_below_i,         // Mode strap below low threshold
    input wire edge_strap_above_i,         // Edge strap above high threshold
    input wire edge_strap_below_i,         // Edge strap below low threshold
    input wire cal_strap_above_i,          // Calibration delay strap above high threshold
    input wire cal_strap_below_i,          // Calibration delay strap below low threshold
    input wire shift_clock_pin_i,          // Serial shift clock pin level
    input wire calibration_busy_i,         // Calibration running, same clock domain
    input wire wb_cyc_i,                   // Wishbone cycle
    input wire wb_stb_i,                   // Wishbone strobe
    input wire wb_we_i,                    // Wishbone write enable
    input wire [7:0] wb_adr_i,             // Wishbone byte address
    input wire [3:0] wb_sel_i,             // Wishbone byte selects
    input wire [31:0] wb_dat_i,            // Wishbone write data
    output reg [31:0] wb_dat_o,            // Wishbone read data
    output reg wb_ack_o,                   // Wishbone acknowledge
    output reg config_valid_o,             // Configuration latched
    output reg extended_mode_o,            // Extended control mode active
    output reg range_810mv_o,              // 810 mV range selected, else 600 mV
    output reg output_edge_select_o,       // Output data on rising edge, else falling
    output reg ddr_output_o,               // Ready clock runs double data rate
    output reg calibration_delay_select_o, // Long calibration delay, else short
    output reg serial_port_enable_o,       // Serial configuration port active
    output reg serial_shift_clock_o,       // Routed serial shift clock
    output reg serial_write_line_o,        // Routed serial data
    output reg serial_port_select_o        // Routed serial select
);
    localparam ST_SETTLE = 1'b0;
    localparam ST_LOCKED = 1'b1;

    wire [2:0] strap_above;
    wire [2:0] strap_below;
    wire [5:0] strap_level;
    wire [2:0] strap_stable;
    wire [2:0] strap_logic;
    wire shift_clock_s;
    wire [1:0] mode_lvl;
    wire [1:0] edge_lvl;
    wire [1:0] cal_lvl;

    reg state_ff;
    reg nxt_state;
    reg relatch_ff;
    reg serial_block_ff;
    reg cal_access_ff;
    reg nxt_extended;
    reg nxt_range;
    reg nxt_edge_pos;
    reg nxt_ddr;
    reg nxt_cal_high;
    reg [31:0] nxt_rdata;

    wire bus_req;
    wire bus_wr;
    wire routed;

    assign strap_above = {cal_strap_above_i, edge_strap_above_i, mode_strap_above_i};
    assign strap_below = {cal_strap_below_i, edge_strap_below_i, mode_strap_below_i};

    // One resolver per strap: index 0 mode, 1 edge, 2 calibration delay
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_strap
            tri_level_resolver u_resolver (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .above_i(strap_above[gi]),
                .below_i(strap_below[gi]),
                .level_o(strap_level[2*gi+1:2*gi]),
                .stable_o(strap_stable[gi]),
                .logic_high_o(strap_logic[gi])
            );
        end
    endgenerate

    level_sync u_sync_shift_clock (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(shift_clock_pin_i),
        .q_o(shift_clock_s)
    );

    assign mode_lvl = strap_level[1:0];
    assign edge_lvl = strap_level[3:2];
    assign cal_lvl = strap_level[5:4];

    // Decode of the live strap levels, captured only on latching
    always @* begin
        nxt_extended = (mode_lvl == `LVL_FLOAT);
        nxt_range = !nxt_extended && (mode_lvl == `LVL_HIGH);
        nxt_ddr = !nxt_extended && (edge_lvl == `LVL_FLOAT);
        nxt_edge_pos = !nxt_extended && (edge_lvl == `LVL_HIGH);
        // Extended mode forces the short delay whatever the pin says
        nxt_cal_high = !nxt_extended && (cal_lvl == `LVL_HIGH);
    end

    // Latch once all straps have settled; straps moving later are ignored
    // until software asks for a relatch.
    always @* begin
        case (state_ff)
            ST_SETTLE: begin
                if (&strap_stable) begin
                    nxt_state = ST_LOCKED;
                end else begin
                    nxt_state = ST_SETTLE;
                end
            end
            ST_LOCKED: begin
                if (relatch_ff) begin
                    nxt_state = ST_SETTLE;
                end else begin
                    nxt_state = ST_LOCKED;
                end
            end
            default: begin
                nxt_state = ST_SETTLE;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_SETTLE;
            config_valid_o <= 1'b0;
            extended_mode_o <= 1'b0;
            range_810mv_o <= 1'b0;
            output_edge_select_o <= 1'b0;
            ddr_output_o <= 1'b0;
            calibration_delay_select_o <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_SETTLE && nxt_state == ST_LOCKED) begin
                config_valid_o <= 1'b1;
                extended_mode_o <= nxt_extended;
                range_810mv_o <= nxt_range;
                output_edge_select_o <= nxt_edge_pos;
                ddr_output_o <= nxt_ddr;
                calibration_delay_select_o <= nxt_cal_high;
            end else if (nxt_state == ST_SETTLE) begin
                config_valid_o <= 1'b0;
            end
        end
    end

    // Serial pins pass through only in a latched extended configuration
    assign routed = config_valid_o && extended_mode_o && !serial_block_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            serial_port_enable_o <= 1'b0;
            serial_shift_clock_o <= 1'b0;
            serial_write_line_o <= 1'b0;
            serial_port_select_o <= 1'b0;
        end else if (routed) begin
            serial_port_enable_o <= 1'b1;
            serial_shift_clock_o <= shift_clock_s;
            serial_write_line_o <= strap_logic[1];
            serial_port_select_o <= strap_logic[2];
        end else begin
            // Pin-controlled mode keeps the port idle
            serial_port_enable_o <= 1'b0;
            serial_shift_clock_o <= 1'b0;
            serial_write_line_o <= 1'b0;
            serial_port_select_o <= 1'b0;
        end
    end

    // Wishbone slave: one wait state, ack pulses for one cycle per request
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

    always @* begin
        nxt_rdata = 32'h00000000;
        case (wb_adr_i)
            `REG_CONTROL: begin
                nxt_rdata[`CTRL_SERIAL_BLOCK_BIT] = serial_block_ff;
            end
            `REG_STATUS: begin
                nxt_rdata[`STAT_MODE_LSB+1:`STAT_MODE_LSB] = mode_lvl;
                nxt_rdata[`STAT_EDGE_LSB+1:`STAT_EDGE_LSB] = edge_lvl;
                nxt_rdata[`STAT_CAL_LSB+1:`STAT_CAL_LSB] = cal_lvl;
                nxt_rdata[`STAT_VALID_BIT] = config_valid_o;
                nxt_rdata[`STAT_EXTENDED_BIT] = extended_mode_o;
                nxt_rdata[`STAT_RANGE_BIT] = range_810mv_o;
                nxt_rdata[`STAT_EDGE_POS_BIT] = output_edge_select_o;
                nxt_rdata[`STAT_DDR_BIT] = ddr_output_o;
                nxt_rdata[`STAT_CAL_HIGH_BIT] = calibration_delay_select_o;
            end
            `REG_VIOLATION: begin
                nxt_rdata[`VIOL_CAL_ACCESS_BIT] = cal_access_ff;
            end
            default: begin
                nxt_rdata = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            relatch_ff <= 1'b0;
            serial_block_ff <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? nxt_rdata : 32'h00000000;
            relatch_ff <= bus_wr && (wb_adr_i == `REG_CONTROL) && wb_dat_i[`CTRL_RELATCH_BIT];
            if (bus_wr && wb_adr_i == `REG_CONTROL) begin
                serial_block_ff <= wb_dat_i[`CTRL_SERIAL_BLOCK_BIT];
            end
        end
    end

    // A select seen during calibration marks a misuse by the host; a new
    // event in the clearing cycle wins over the clear.
    always @(posedge clk_i) begin
        if (rst_i) begin
            cal_access_ff <= 1'b0;
        end else if (calibration_busy_i && serial_port_select_o) begin
            cal_access_ff <= 1'b1;
        end else if (bus_wr && wb_adr_i == `REG_VIOLATION && wb_dat_i[`VIOL_CAL_ACCESS_BIT]) begin
            cal_access_ff <= 1'b0;
        end
    end
endmodule

// ---- hw/strap_map.vh ----
// Constants for the control mode strap decoder: register map, field
// positions, reset values, strap level codes and settle timing.
// Assumes inclusion by bare name from the design files under hw/.
`ifndef STRAP_MAP_VH
`define STRAP_MAP_VH

// Clock rate and strap settle time
`define CLK_FREQ_MHZ 100
`define STRAP_SETTLE_NS 1000
`define STRAP_SETTLE_CYC ((`STRAP_SETTLE_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define SETTLE_CNT_W 8
// Last count of the settle counter: STRAP_SETTLE_CYC - 1 at SETTLE_CNT_W bits,
// kept sized so the compare does not widen; keep in step with the settle time
`define STRAP_SETTLE_LAST 8'h63

// Resolved strap level codes
`define LVL_LOW 2'h0
`define LVL_HIGH 2'h1
`define LVL_FLOAT 2'h2

// Register byte offsets (word aligned)
`define REG_CONTROL 8'h00
`define REG_STATUS 8'h04
`define REG_VIOLATION 8'h08

// Control register fields
`define CTRL_RELATCH_BIT 0
`define CTRL_SERIAL_BLOCK_BIT 1
`define CTRL_RESET 2'h0

// Status register fields
`define STAT_MODE_LSB 0
`define STAT_EDGE_LSB 2
`define STAT_CAL_LSB 4
`define STAT_VALID_BIT 6
`define STAT_EXTENDED_BIT 7
`define STAT_RANGE_BIT 8
`define STAT_EDGE_POS_BIT 9
`define STAT_DDR_BIT 10
`define STAT_CAL_HIGH_BIT 11

// Violation register fields
`define VIOL_CAL_ACCESS_BIT 0

`endif

// ---- hw/level_sync.v ----
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to clk_i.
`timescale 1ns/100ps
module level_sync (
    input wire clk_i,  // System clock
    input wire rst_i,  // Synchronous reset, active high
    input wire d_i,    // Asynchronous level
    output wire q_o    // Synchronised level
);
    reg meta_ff;
    reg sync_ff;

    // The first stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule

// ---- hw/tri_level_resolver.v ----
// Resolves one three-level strap pin from a window comparator pair
// into low, high or floating, and reports when the level has settled.
// Assumes the comparator outputs are asynchronous to clk_i.
`timescale 1ns/100ps
`include "strap_map.vh"
module tri_level_resolver (
    input wire clk_i,           // System clock
    input wire rst_i,           // Synchronous reset, active high
    input wire above_i,         // Pin is above the high threshold
    input wire below_i,         // Pin is below the low threshold
    output reg [1:0] level_o,   // Resolved level code
    output reg stable_o,        // Level unchanged for the settle time
    output wire logic_high_o    // Synchronised plain logic level of the pin
);
    wire above_s;
    wire below_s;
    reg [1:0] nxt_level;
    reg [`SETTLE_CNT_W-1:0] settle_ff;

    level_sync u_sync_above (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(above_i),
        .q_o(above_s)
    );

    level_sync u_sync_below (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(below_i),
        .q_o(below_s)
    );

    // Both comparators tripping is impossible on a sane pin; call it floating
    always @* begin
        if (above_s && !below_s) begin
            nxt_level = `LVL_HIGH;
        end else if (below_s && !above_s) begin
            nxt_level = `LVL_LOW;
        end else begin
            nxt_level = `LVL_FLOAT;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= `LVL_FLOAT;
            settle_ff <= {`SETTLE_CNT_W{1'b0}};
            stable_o <= 1'b0;
        end else begin
            level_o <= nxt_level;
            if (nxt_level != level_o) begin
                settle_ff <= {`SETTLE_CNT_W{1'b0}};
                stable_o <= 1'b0;
            end else if (settle_ff == `STRAP_SETTLE_LAST) begin
                stable_o <= 1'b1;
            end else begin
                settle_ff <= settle_ff + {{(`SETTLE_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    assign logic_high_o = above_s;
endmodule

// ---- tb/strap_board_model.sv ----
// Board and host side: turns requested pin levels into comparator pairs.
// Assumes the level codes of strap_map.vh and a host that drives the serial pins.
`timescale 1ns/100ps
`include "strap_map.vh"
module strap_board_model (
    input wire [1:0] mode_lvl_i, // Mode strap level
    input wire [1:0] edge_lvl_i, // Edge strap or serial data level
    input wire [1:0] cal_lvl_i,  // Cal strap or select level
    input wire sclk_i,           // Host shift clock
    output wire [5:0] cmp_o,     // Above/below pairs
    output wire shift_clock_pin_o // Shift clock pin
);
    // A floating pin sits between thresholds, so neither comparator trips
    function automatic [1:0] pin(input [1:0] l);
        pin = {l == `LVL_HIGH, l == `LVL_LOW};
    endfunction
    assign cmp_o = {pin(mode_lvl_i), pin(edge_lvl_i), pin(cal_lvl_i)};
    assign shift_clock_pin_o = sclk_i;
endmodule

// ---- tb/control_mode_strap_decoder_checker.sv ----
// Port checks for the strap decoder.
// Assumes it is bound onto control_mode_strap_decoder; one clock domain.
`timescale 1ns/100ps
module control_mode_strap_decoder_checker (
    input wire clk_i, // Clock
    input wire rst_i, // Reset
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    input wire wb_we_i, // Write
    input wire [7:0] wb_adr_i, // Address
    input wire [3:0] wb_sel_i, // Selects
    input wire [31:0] wb_dat_i, // Write data
    input wire wb_ack_o, // Ack
    input wire config_valid_o, // Latched
    input wire extended_mode_o, // Extended
    input wire range_810mv_o, // Range
    input wire output_edge_select_o, // Edge
    input wire ddr_output_o, // DDR
    input wire calibration_delay_select_o, // Cal delay
    input wire serial_port_enable_o, // Routing on
    input wire serial_shift_clock_o, // Shift clock out
    input wire serial_write_line_o, // Data out
    input wire serial_port_select_o, // Select out
    input wire shift_clock_pin_i, // Shift clock pin
    input wire edge_strap_above_i, // Data pin
    input wire cal_strap_above_i // Select pin
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [4:0] dec = {extended_mode_o, range_810mv_o, output_edge_select_o, ddr_output_o, calibration_delay_select_o};
    wire relatch = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[0];

    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_pin_off; !extended_mode_o && !$past(extended_mode_o) |-> !serial_port_enable_o; endproperty
    a_pin_off: assert property (p_pin_off) else $error("serial on in pin mode");
    property p_ext_dec; extended_mode_o |-> dec[3:0] == 4'h0; endproperty
    a_ext_dec: assert property (p_ext_dec) else $error("extended decode wrong");
    property p_ddr; ddr_output_o |-> !output_edge_select_o && !extended_mode_o; endproperty
    a_ddr: assert property (p_ddr) else $error("ddr with edge");
    property p_static; config_valid_o && $past(config_valid_o) |-> $stable(dec); endproperty
    a_static: assert property (p_static) else $error("decode moved");
    property p_serial; serial_port_enable_o && $past(serial_port_enable_o) |->
        serial_shift_clock_o == $past(shift_clock_pin_i, 3) && serial_write_line_o == $past(edge_strap_above_i, 3);
    endproperty
    a_serial: assert property (p_serial) else $error("serial pass wrong");
    property p_select; serial_port_enable_o && $past(serial_port_enable_o) |->
        serial_port_select_o == $past(cal_strap_above_i, 3); endproperty
    a_select: assert property (p_select) else $error("select pass wrong");
    property p_serial_off; !serial_port_enable_o && !$past(serial_port_enable_o) |->
        !(serial_shift_clock_o || serial_write_line_o || serial_port_select_o); endproperty
    a_serial_off: assert property (p_serial_off) else $error("serial out while off");
    property p_relatch; relatch |-> ##2 !config_valid_o; endproperty
    a_relatch: assert property (p_relatch) else $error("relatch ignored");
endmodule
bind control_mode_strap_decoder control_mode_strap_decoder_checker control_mode_strap_decoder_checker_i (.*);

// ---- tb/control_mode_strap_decoder_tb_top.sv ----
// Testbench for the strap decoder: strap cases, serial routing, registers.
// Assumes strap_map.vh on the include path and the board model beside it.
`timescale 1ns/100ps
`include "strap_map.vh"
module control_mode_strap_decoder_tb_top;
    reg clk_i = 0, rst_i = 1, calibration_busy_i = 0, sclk = 0;
    reg wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h0, rd;
    reg [1:0] ml = `LVL_LOW, el = `LVL_LOW, cl = `LVL_LOW;
    wire mode_strap_above_i, mode_strap_below_i, edge_strap_above_i, edge_strap_below_i;
    wire cal_strap_above_i, cal_strap_below_i, shift_clock_pin_i, wb_ack_o, config_valid_o;
    wire [31:0] wb_dat_o;
    wire extended_mode_o, range_810mv_o, output_edge_select_o, ddr_output_o, calibration_delay_select_o;
    wire serial_port_enable_o, serial_shift_clock_o, serial_write_line_o, serial_port_select_o;
    integer err_count = 0, n_checks = 0, cycles = 0;
    control_mode_strap_decoder control_mode_strap_decoder_i (.*);
    strap_board_model strap_board_model_i (.mode_lvl_i(ml), .edge_lvl_i(el), .cal_lvl_i(cl), .sclk_i(sclk),
        .cmp_o({mode_strap_above_i, mode_strap_below_i, edge_strap_above_i, edge_strap_below_i,
        cal_strap_above_i, cal_strap_below_i}), .shift_clock_pin_o(shift_clock_pin_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Each case needs about 110 cycles to settle; the whole run stays far below this
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            report_and_stop;
        end
    end
    task chk(input [8*10:1] what, input [31:0] exp, input [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %0s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One classic cycle; the next call idles a cycle before raising the strobe again
    task wb_io(input w, input [7:0] a, input [31:0] d, input [3:0] s);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, s};
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task wait_valid;
        integer i;
        for (i = 0; i < 400 && config_valid_o !== 1'b1; i = i + 1) @(posedge clk_i);
        // Serial enable follows the latch by one flop stage
        @(posedge clk_i);
        chk("valid", 32'h1, {31'h0, config_valid_o});
    endtask
    // x holds extended, range, edge, ddr and cal delay from high bit down
    task run_case(input [1:0] m, input [1:0] e, input [1:0] c, input [4:0] x);
        @(posedge clk_i);
        {ml, el, cl, rst_i} <= {m, e, c, 1'b1};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_valid;
        chk("decoded", {27'h0, x}, {27'h0, extended_mode_o, range_810mv_o, output_edge_select_o,
            ddr_output_o, calibration_delay_select_o});
        chk("serial_en", {31'h0, x[4]}, {31'h0, serial_port_enable_o});
        wb_io(1'b0, `REG_STATUS, 32'h0, 4'hf);
        chk("status", {20'h0, x[0], x[1], x[2], x[3], x[4], 1'b1, c, e, m}, rd);
    endtask
    task serial_out(input [31:0] exp);
        repeat (4) @(posedge clk_i);
        chk("serial", exp, {29'h0, serial_shift_clock_o, serial_write_line_o, serial_port_select_o});
    endtask
    initial begin
        run_case(`LVL_LOW, `LVL_LOW, `LVL_LOW, 5'h00);
        run_case(`LVL_HIGH, `LVL_HIGH, `LVL_HIGH, 5'h0d);
        run_case(`LVL_LOW, `LVL_FLOAT, `LVL_HIGH, 5'h03);
        run_case(`LVL_HIGH, `LVL_FLOAT, `LVL_LOW, 5'h0a);
        run_case(`LVL_FLOAT, `LVL_HIGH, `LVL_HIGH, 5'h10);
        {sclk, el} <= {1'b1, `LVL_HIGH};
        serial_out(32'h7);
        {sclk, el} <= {1'b0, `LVL_LOW};
        serial_out(32'h1);
        ml <= `LVL_LOW;
        repeat (150) @(posedge clk_i);
        chk("locked", 32'h1, {31'h0, extended_mode_o});
        calibration_busy_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        calibration_busy_i <= 1'b0;
        wb_io(1'b0, `REG_VIOLATION, 32'h0, 4'hf);
        chk("violation", 32'h1, rd);
        wb_io(1'b1, `REG_VIOLATION, 32'h1, 4'hf);
        wb_io(1'b0, `REG_VIOLATION, 32'h0, 4'hf);
        chk("violation", 32'h0, rd);
        wb_io(1'b1, `REG_CONTROL, 32'h2, 4'he);
        wb_io(1'b0, `REG_CONTROL, 32'h0, 4'hf);
        chk("control", 32'h0, rd);
        wb_io(1'b1, `REG_CONTROL, 32'h2, 4'hf);
        wb_io(1'b0, `REG_CONTROL, 32'h0, 4'hf);
        chk("control", 32'h2, rd);
        chk("serial_en", 32'h0, {31'h0, serial_port_enable_o});
        wb_io(1'b0, 8'h0c, 32'h0, 4'hf);
        chk("unmapped", 32'h0, rd);
        wb_io(1'b1, `REG_CONTROL, 32'h1, 4'hf);
        // Settled straps latch again one cycle after valid drops
        @(posedge clk_i);
        chk("relatch", 32'h0, {31'h0, config_valid_o});
        wait_valid;
        chk("decoded", 32'h1, {27'h0, extended_mode_o, range_810mv_o, output_edge_select_o,
            ddr_output_o, calibration_delay_select_o});
        report_and_stop;
    end
endmodule
